// File: bench/kpcr_asserts.sv
// Checker for the management register slice, bound to kpcr_regs.
// Assumes the station runs mdc at eight mclk cycles a bit.
`timescale 1ns/1ps
module kpcr_asserts (
  // Clock and reset
  input wire       mclk,
  input wire       rst,
  // Management port
  input wire       mdc,
  input wire       mdio_out,
  input wire       mdio_oe,
  // Controls
  input wire [3:0] square_wave_run_length,
  input wire       rx_control_char_pass,
  input wire       rx_descrambler_off,
  input wire       tx_scrambler_off,
  input wire       negotiation_reset,
  input wire       negotiation_enable,
  input wire       negotiation_restart
);
  reg       mdc_q;
  reg [4:0] rises;
  // Counts mdc rises while the device holds the line
  always @(posedge mclk) begin
    mdc_q <= mdc;
    if (rst || !mdio_oe)
      rises <= 5'h00;
    else if (mdc && !mdc_q)
      rises <= rises + 5'h01;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  sqwave_hold_a: assert property (
    mdio_oe |-> $stable(square_wave_run_length))
    else $error("run length moved during a read");
  pcs_ctrl_hold_a: assert property (
    mdio_oe |-> $stable({rx_control_char_pass, rx_descrambler_off,
                         tx_scrambler_off}))
    else $error("pcs control moved during a read");
  enable_write_a: assert property (
    $changed(negotiation_enable) |-> !mdio_oe && !$past(mdio_oe))
    else $error("enable changed while a read was answered");
  reset_pulse_a: assert property (
    negotiation_reset |=> !negotiation_reset)
    else $error("negotiation reset did not clear itself");
  restart_read_a: assert property (
    $fell(negotiation_restart) && !$past(rst) |-> ##[1:40] mdio_oe)
    else $error("restart cleared without a read");
  restart_hold_a: assert property (
    mdio_oe |-> $stable(negotiation_restart))
    else $error("restart moved during read data");
  turn_zero_a: assert property (
    $rose(mdio_oe) |-> !mdio_out ##1 (mdio_oe && !mdio_out) [*5])
    else $error("turnaround slot not driven low");
  frame_len_a: assert property (
    $fell(mdio_oe) && !$past(rst) |-> rises == 5'h11)
    else $error("read answer not seventeen slots long");
endmodule // kpcr_asserts

bind kpcr_regs kpcr_asserts chk_u (
  .mclk(mclk), .rst(rst), .mdc(mdc), .mdio_out(mdio_out),
  .mdio_oe(mdio_oe), .square_wave_run_length(square_wave_run_length),
  .rx_control_char_pass(rx_control_char_pass),
  .rx_descrambler_off(rx_descrambler_off),
  .tx_scrambler_off(tx_scrambler_off),
  .negotiation_reset(negotiation_reset),
  .negotiation_enable(negotiation_enable),
  .negotiation_restart(negotiation_restart)
);

// File: bench/kpcr_station.sv
// Management station model: makes mdc and frames on the data line.
// Assumes callers enter frm just after an mclk rising edge.
`timescale 1ns/1ps
module kpcr_station #(
  parameter PRT = 5'h01
) (
  // Clock
  input  wire mclk,
  // Device side of the line
  input  wire mdio_oe,
  input  wire mdio_out,
  // Station side
  output reg  mdc,
  output wire mdio_in
);
  reg drv;
  reg val;
  // Released line rests at its pull-up level
  assign mdio_in = mdio_oe ? mdio_out : (drv ? val : 1'b1);
  initial begin
    mdc = 1'b0;
    drv = 1'b0;
    val = 1'b1;
  end
  task automatic frm(input [1:0] op, input [4:0] dv,
                     input [15:0] d, output [15:0] q);
    reg [63:0] v;
    integer    i;
    begin
      v = {32'hffffffff, 2'b00, op, PRT, dv, 2'b10, d};
      q = 16'h0000;
      for (i = 63; i >= 0; i = i - 1) begin
        mdc = 1'b0;
        // Reads hand the line over at turnaround
        drv = !(op[1] && i < 18);
        val = v[i];
        repeat (4) @(posedge mclk);
        #1;
        if (i < 16)
          q[i] = mdio_in;
        mdc = 1'b1;
        repeat (4) @(posedge mclk);
        #1;
      end
      mdc = 1'b0;
      drv = 1'b0;
      // Let an edge pass so the next frame never re-drives in this step
      @(posedge mclk);
      #1;
    end
  endtask
endmodule // kpcr_station

// File: bench/tb.sv
// Self-checking bench for the management register slice.
// Assumes the station model owns mdc and the shared data line.
`timescale 1ns/1ps
`define CHK(a, b) \
  begin \
    tests_run = tests_run + 1; \
    if ((a) !== (b)) begin \
      n_errors = n_errors + 1; \
      $display("Error %0t: got %h exp %h", $time, a, b); \
    end \
  end
module tb;
  reg         mclk;
  reg         rst;
  reg  [2:0]  ev;
  reg  [3:0]  an;
  reg         link;
  reg         lp;
  reg         seen;
  wire        mdc;
  wire        mdio_in;
  wire        mdio_out;
  wire        mdio_oe;
  wire [3:0]  run_len;
  wire        pass;
  wire        dscr_off;
  wire        scr_off;
  wire        neg_rst;
  wire        neg_en;
  wire        neg_rs;
  integer     n_errors;
  integer     tests_run;
  kpcr_regs dut_u (
    .mclk(mclk), .rst(rst), .mdc(mdc), .mdio_in(mdio_in),
    .mdio_out(mdio_out), .mdio_oe(mdio_oe), .port_addr(5'h01),
    .fec_uncorrectable_event(ev[2]), .fec_correctable_event(ev[1]),
    .pattern_check_event(ev[0]), .negotiation_done_in(an[0]),
    .parallel_detect_fault_in(an[1]), .page_received_in(an[2]),
    .remote_fault_in(an[3]), .link_up_in(link), .lp_ability_in(lp),
    .square_wave_run_length(run_len), .rx_control_char_pass(pass),
    .rx_descrambler_off(dscr_off), .tx_scrambler_off(scr_off),
    .negotiation_reset(neg_rst), .negotiation_enable(neg_en),
    .negotiation_restart(neg_rs)
  );
  kpcr_station st_u (
    .mclk(mclk), .mdio_oe(mdio_oe), .mdio_out(mdio_out),
    .mdc(mdc), .mdio_in(mdio_in)
  );
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // Reset pulse lasts one cycle, so catch it here
  always @(posedge mclk)
    if (rst)
      seen <= 1'b0;
    else if (neg_rst)
      seen <= 1'b1;
  task automatic settle;
    begin
      repeat (4) @(posedge mclk);
      #1;
    end
  endtask
  task automatic wr(input [4:0] dv, input [15:0] a, input [15:0] d);
    reg [15:0] x;
    begin
      st_u.frm(2'h0, dv, a, x);
      st_u.frm(2'h1, dv, d, x);
      settle;
    end
  endtask
  task automatic rd(input [4:0] dv, input [15:0] a, input [15:0] e);
    reg [15:0] x;
    begin
      st_u.frm(2'h0, dv, a, x);
      st_u.frm(2'h3, dv, 16'h0000, x);
      settle;
      `CHK(x, e)
    end
  endtask
  task automatic t_reset;
    begin
      `CHK({run_len, pass, dscr_off, scr_off}, 7'h58)
      `CHK({neg_en, neg_rs, neg_rst}, 3'h4)
      rd(5'h03, 16'h8000, 16'h00b0);
      rd(5'h03, 16'h8010, 16'h00fd);
      rd(5'h07, 16'h0000, 16'h3000);
      rd(5'h07, 16'h0001, 16'h0088);
    end
  endtask
  task automatic t_vctrl;
    begin
      wr(5'h03, 16'h8000, 16'hff52);
      `CHK({run_len, pass, dscr_off, scr_off}, 7'h2a)
      rd(5'h03, 16'h8000, 16'h0052);
      wr(5'h03, 16'h8000, 16'h00ad);
      `CHK({run_len, pass, dscr_off, scr_off}, 7'h55)
      rd(5'h03, 16'h8000, 16'h00a5);
    end
  endtask
  task automatic t_pcs_stat;
    integer j;
    begin
      for (j = 0; j < 3; j = j + 1) begin
        ev = 3'b001 << j;
        @(posedge mclk);
        #1;
        ev = 3'b000;
        settle;
        rd(5'h03, 16'h8010, {2'b00, j == 2, j == 1, 3'b000, j == 0,
           8'hfd});
        rd(5'h03, 16'h8010, 16'h00fd);
      end
    end
  endtask
  task automatic t_an_stat;
    reg [15:0] p;
    integer    j;
    begin
      p = 16'h4695;
      link = 1'b1;
      lp = 1'b1;
      settle;
      rd(5'h07, 16'h0001, 16'h0089);
      rd(5'h07, 16'h0001, 16'h008d);
      for (j = 0; j < 4; j = j + 1) begin
        an = 4'h1 << j;
        @(posedge mclk);
        #1;
        an = 4'h0;
        settle;
        rd(5'h07, 16'h0001, 16'h008d | (16'h0001 << p[j*4 +: 4]));
        rd(5'h07, 16'h0001, 16'h008d);
      end
      link = 1'b0;
      @(posedge mclk);
      #1;
      link = 1'b1;
      rd(5'h07, 16'h0001, 16'h0089);
      rd(5'h07, 16'h0001, 16'h008d);
    end
  endtask
  task automatic t_an_ctrl;
    begin
      wr(5'h07, 16'h0000, 16'h8200);
      `CHK({seen, neg_rst, neg_en, neg_rs}, 4'h9)
      // station reads control to clear restart
      rd(5'h07, 16'h0000, 16'h0200);
      `CHK(neg_rs, 1'b0)
      rd(5'h07, 16'h0000, 16'h0000);
      wr(5'h07, 16'h0000, 16'h3000);
      `CHK(neg_en, 1'b1)
    end
  endtask
  task automatic t_dev;
    reg [15:0] x;
    begin
      rd(5'h03, 16'h0000, 16'h0000);
      rd(5'h05, 16'h0000, 16'hffff);
      wr(5'h03, 16'h0000, 16'h0000);
      rd(5'h07, 16'h0000, 16'h3000);
      // Read with post-increment steps the device 3 address
      st_u.frm(2'h0, 5'h03, 16'h800f, x);
      st_u.frm(2'h2, 5'h03, 16'h0000, x);
      `CHK(x, 16'h0000)
      st_u.frm(2'h3, 5'h03, 16'h0000, x);
      `CHK(x, 16'h00fd)
    end
  endtask
  task complete_run;
    begin
      $display("Checks %0d, mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  initial begin
    rst = 1'b1;
    ev = 3'b000;
    an = 4'h0;
    link = 1'b0;
    lp = 1'b0;
    n_errors = 0;
    tests_run = 0;
    repeat (2) @(posedge mclk);
    #1;
    rst = 1'b0;
    settle;
    t_reset;
    t_vctrl;
    t_pcs_stat;
    t_an_stat;
    t_an_ctrl;
    t_dev;
    complete_run;
  end
endmodule // tb

// File: hdl/kpcr_defines.vh
// Constants for the KR PCS and negotiation management register slice.
// Assumes inclusion by the top module only; its latch-bit helper does not include it.
`ifndef KPCR_DEFINES_VH
`define KPCR_DEFINES_VH

// Management frame fields
`define KPCR_PREAMBLE_BITS   6'h20
`define KPCR_OP_ADDR         2'h0
`define KPCR_OP_WRITE        2'h1
`define KPCR_OP_READ_INC     2'h2
`define KPCR_OP_READ         2'h3
`define KPCR_HDR_LAST        6'h0b
`define KPCR_DATA_LAST       6'h0f

// Device addresses
`define KPCR_DEV_PCS         5'h03
`define KPCR_DEV_AN          5'h07

// Register offsets
`define KPCR_PCS_VCTRL_OFS   16'h8000
`define KPCR_PCS_VSTAT_OFS   16'h8010
`define KPCR_AN_CTRL_OFS     16'h0000
`define KPCR_AN_STAT_OFS     16'h0001

// Reset values
`define KPCR_PCS_VCTRL_RST   16'h00b0
`define KPCR_PCS_VSTAT_LOW   8'hfd
`define KPCR_AN_CTRL_RST     16'h3000
`define KPCR_AN_STAT_RST     16'h0088
`define KPCR_SQWAVE_RST      4'hb

// Vendor control field positions
`define KPCR_SQWAVE_MSB      7
`define KPCR_SQWAVE_LSB      4
`define KPCR_CTRL_CHAR_BIT   2
`define KPCR_DESCR_OFF_BIT   1
`define KPCR_SCR_OFF_BIT     0

// Vendor status field positions
`define KPCR_UNCORR_BIT      13
`define KPCR_CORR_BIT        12
`define KPCR_TP_ERR_BIT      8

// Negotiation control field positions
`define KPCR_NEGOTIATION_RESET_BIT    15
`define KPCR_AN_RSVD13_BIT   13
`define KPCR_NEGOTIATION_ENABLE_BIT   12
`define KPCR_NEGOTIATION_RESTART_BIT  9

// Negotiation status field positions
`define KPCR_PDF_BIT         9
`define KPCR_EXP_NP_BIT      7
`define KPCR_PAGE_BIT        6
`define KPCR_DONE_BIT        5
`define KPCR_RFAULT_BIT      4
`define KPCR_ABILITY_BIT     3
`define KPCR_LINK_BIT        2
`define KPCR_LP_ABILITY_BIT  0

`endif

// File: hdl/kpcr_latch_bit.v
// Latched status bit, cleared by a read of its register.
// Assumes cond and rd_clear are synchronous to mclk.
`timescale 1ns/1ps
module kpcr_latch_bit #(
  parameter ACT_LOW = 0
) (
  // Clock and reset
  input  wire mclk,
  input  wire rst,
  // Condition and read strobe
  input  wire cond,
  input  wire rd_clear,
  // Latched value
  output reg  flag
);
  reg next_flag;

  // Event in the read cycle is kept: set wins over clear
  always @* begin
    if (ACT_LOW != 0)
      next_flag = cond & (flag | rd_clear);
    else
      next_flag = cond | (flag & ~rd_clear);
  end

  always @(posedge mclk) begin
    if (rst)
      flag <= 1'b0;
    else
      flag <= next_flag;
  end
endmodule // kpcr_latch_bit

// File: hdl/kpcr_regs.v
// Management register slice: KR PCS vendor control and status, and
// negotiation control and status, behind a Clause 45 management port.
// Assumes mdc and mdio_in are already synchronous to mclk, mdc far slower.
`timescale 1ns/1ps
`include "kpcr_defines.vh"
module kpcr_regs (
  // Clock and reset
  input  wire       mclk,
  input  wire       rst,
  // Management port
  input  wire       mdc,
  input  wire       mdio_in,
  output reg        mdio_out,
  output reg        mdio_oe,
  input  wire [4:0] port_addr,
  // PCS events
  input  wire       fec_uncorrectable_event,
  input  wire       fec_correctable_event,
  input  wire       pattern_check_event,
  // Negotiation status inputs
  input  wire       negotiation_done_in,
  input  wire       parallel_detect_fault_in,
  input  wire       page_received_in,
  input  wire       remote_fault_in,
  input  wire       link_up_in,
  input  wire       lp_ability_in,
  // PCS controls
  output reg  [3:0] square_wave_run_length,
  output reg        rx_control_char_pass,
  output reg        rx_descrambler_off,
  output reg        tx_scrambler_off,
  // Negotiation controls
  output reg        negotiation_reset,
  output reg        negotiation_enable,
  output reg        negotiation_restart
);
  localparam S_PRE = 3'h0;
  localparam S_ST  = 3'h1;
  localparam S_HDR = 3'h2;
  localparam S_TA  = 3'h3;
  localparam S_DAT = 3'h4;

  reg  [2:0]  state;
  reg  [5:0]  cnt;
  reg  [11:0] hdr;
  reg  [15:0] sh;
  reg  [15:0] addr_pcs;
  reg  [15:0] addr_an;
  reg         mdc_d;
  reg         respond;
  reg         an_rsvd13;
  reg  [15:0] rd_val;

  wire        mdc_rise = mdc & ~mdc_d;
  wire [11:0] hdr_full = {hdr[10:0], mdio_in};
  wire [1:0]  n_op     = hdr_full[11:10];
  wire [4:0]  n_prt    = hdr_full[9:5];
  wire [4:0]  n_dev    = hdr_full[4:0];
  wire [1:0]  h_op     = hdr[11:10];
  wire [4:0]  h_dev    = hdr[4:0];
  wire [15:0] dat_full = {sh[14:0], mdio_in};

  // only device 3 and device 7 are served
  wire n_hit = (n_prt == port_addr) &&
               ((n_dev == `KPCR_DEV_PCS) || (n_dev == `KPCR_DEV_AN));
  wire n_rd  = (n_op == `KPCR_OP_READ) || (n_op == `KPCR_OP_READ_INC);
  wire hdr_done = mdc_rise && (state == S_HDR) && (cnt == `KPCR_HDR_LAST);
  wire rd_hit   = hdr_done && n_hit && n_rd;
  wire dat_done = mdc_rise && (state == S_DAT) && (cnt == `KPCR_DATA_LAST);
  wire wr_hit   = dat_done && respond && (h_op == `KPCR_OP_WRITE);
  wire [15:0] n_addr = (n_dev == `KPCR_DEV_AN) ? addr_an : addr_pcs;
  wire [15:0] h_addr = (h_dev == `KPCR_DEV_AN) ? addr_an : addr_pcs;
  wire rd_pcs_stat = rd_hit && (n_dev == `KPCR_DEV_PCS) &&
                     (n_addr == `KPCR_PCS_VSTAT_OFS);
  wire rd_an_stat  = rd_hit && (n_dev == `KPCR_DEV_AN) &&
                     (n_addr == `KPCR_AN_STAT_OFS);
  wire rd_an_ctrl  = rd_hit && (n_dev == `KPCR_DEV_AN) &&
                     (n_addr == `KPCR_AN_CTRL_OFS);
  wire wr_pcs_ctrl = wr_hit && (h_dev == `KPCR_DEV_PCS) &&
                     (h_addr == `KPCR_PCS_VCTRL_OFS);
  wire wr_an_ctrl  = wr_hit && (h_dev == `KPCR_DEV_AN) &&
                     (h_addr == `KPCR_AN_CTRL_OFS);
  wire unc_flag;
  wire cor_flag;
  wire tp_flag;
  wire pdf_flag;
  wire page_flag;
  wire done_flag;
  wire rf_flag;
  wire link_flag;
  kpcr_latch_bit #(.ACT_LOW(0)) u_unc (
    .mclk     (mclk),
    .rst      (rst),
    .cond     (fec_uncorrectable_event),
    .rd_clear (rd_pcs_stat),
    .flag     (unc_flag)
  );
  kpcr_latch_bit #(.ACT_LOW(0)) u_cor (
    .mclk     (mclk),
    .rst      (rst),
    .cond     (fec_correctable_event),
    .rd_clear (rd_pcs_stat),
    .flag     (cor_flag)
  );
  kpcr_latch_bit #(.ACT_LOW(0)) u_tp (
    .mclk     (mclk),
    .rst      (rst),
    .cond     (pattern_check_event),
    .rd_clear (rd_pcs_stat),
    .flag     (tp_flag)
  );
  kpcr_latch_bit #(.ACT_LOW(0)) u_pdf (
    .mclk     (mclk),
    .rst      (rst),
    .cond     (parallel_detect_fault_in),
    .rd_clear (rd_an_stat),
    .flag     (pdf_flag)
  );
  kpcr_latch_bit #(.ACT_LOW(0)) u_page (
    .mclk     (mclk),
    .rst      (rst),
    .cond     (page_received_in),
    .rd_clear (rd_an_stat),
    .flag     (page_flag)
  );
  kpcr_latch_bit #(.ACT_LOW(0)) u_done (
    .mclk     (mclk),
    .rst      (rst),
    .cond     (negotiation_done_in),
    .rd_clear (rd_an_stat),
    .flag     (done_flag)
  );
  kpcr_latch_bit #(.ACT_LOW(0)) u_rf (
    .mclk     (mclk),
    .rst      (rst),
    .cond     (remote_fault_in),
    .rd_clear (rd_an_stat),
    .flag     (rf_flag)
  );
  kpcr_latch_bit #(.ACT_LOW(1)) u_link (
    .mclk     (mclk),
    .rst      (rst),
    .cond     (link_up_in),
    .rd_clear (rd_an_stat),
    .flag     (link_flag)
  );
  // Read mux; unmapped offsets of a served device read zero
  always @* begin
    rd_val = 16'h0000;
    if (n_dev == `KPCR_DEV_PCS) begin
      if (n_addr == `KPCR_PCS_VCTRL_OFS) begin
        rd_val[`KPCR_SQWAVE_MSB:`KPCR_SQWAVE_LSB] = square_wave_run_length;
        rd_val[`KPCR_CTRL_CHAR_BIT] = rx_control_char_pass;
        rd_val[`KPCR_DESCR_OFF_BIT] = rx_descrambler_off;
        rd_val[`KPCR_SCR_OFF_BIT]   = tx_scrambler_off;
      end else if (n_addr == `KPCR_PCS_VSTAT_OFS) begin
        rd_val[7:0]               = `KPCR_PCS_VSTAT_LOW;
        rd_val[`KPCR_UNCORR_BIT]  = unc_flag;
        rd_val[`KPCR_CORR_BIT]    = cor_flag;
        rd_val[`KPCR_TP_ERR_BIT]  = tp_flag;
      end
    end else begin
      if (n_addr == `KPCR_AN_CTRL_OFS) begin
        rd_val[`KPCR_NEGOTIATION_RESET_BIT]   = negotiation_reset;
        rd_val[`KPCR_AN_RSVD13_BIT]  = an_rsvd13;
        rd_val[`KPCR_NEGOTIATION_ENABLE_BIT]  = negotiation_enable;
        rd_val[`KPCR_NEGOTIATION_RESTART_BIT] = negotiation_restart;
      end else if (n_addr == `KPCR_AN_STAT_OFS) begin
        rd_val[`KPCR_PDF_BIT]        = pdf_flag;
        rd_val[`KPCR_EXP_NP_BIT]     = 1'b1;
        rd_val[`KPCR_PAGE_BIT]       = page_flag;
        rd_val[`KPCR_DONE_BIT]       = done_flag;
        rd_val[`KPCR_RFAULT_BIT]     = rf_flag;
        rd_val[`KPCR_ABILITY_BIT]    = 1'b1;
        rd_val[`KPCR_LINK_BIT]       = link_flag;
        rd_val[`KPCR_LP_ABILITY_BIT] = lp_ability_in;
      end
    end
  end

  // Frame engine; bits sampled and driven on mdc rising edges
  always @(posedge mclk) begin
    if (rst) begin
      mdc_d    <= 1'b0;
      state    <= S_PRE;
      cnt      <= 6'h00;
      hdr      <= 12'h000;
      sh       <= 16'h0000;
      respond  <= 1'b0;
      mdio_out <= 1'b0;
      mdio_oe  <= 1'b0;
      addr_pcs <= 16'h0000;
      addr_an  <= 16'h0000;
    end else begin
      mdc_d <= mdc;
      if (mdc_rise) begin
        case (state)
          S_PRE: begin
            if (mdio_in) begin
              if (cnt != `KPCR_PREAMBLE_BITS)
                cnt <= cnt + 6'h01;
            end else if (cnt == `KPCR_PREAMBLE_BITS) begin
              state <= S_ST;
            end else begin
              cnt <= 6'h00;
            end
          end
          S_ST: begin
            cnt   <= 6'h00;
            state <= mdio_in ? S_PRE : S_HDR;
          end
          S_HDR: begin
            hdr <= hdr_full;
            if (cnt == `KPCR_HDR_LAST) begin
              cnt     <= 6'h00;
              state   <= S_TA;
              respond <= n_hit;
              sh      <= rd_val;
              if (n_hit && (n_op == `KPCR_OP_READ_INC)) begin
                if (n_dev == `KPCR_DEV_AN)
                  addr_an <= addr_an + 16'h0001;
                else
                  addr_pcs <= addr_pcs + 16'h0001;
              end
            end else begin
              cnt <= cnt + 6'h01;
            end
          end
          S_TA: begin
            // First turnaround bit floats, second is driven low
            if (cnt == 6'h00) begin
              cnt <= 6'h01;
              if (respond && h_op[1]) begin
                mdio_oe  <= 1'b1;
                mdio_out <= 1'b0;
              end
            end else begin
              cnt   <= 6'h00;
              state <= S_DAT;
              if (respond && h_op[1]) begin
                mdio_out <= sh[15];
                sh       <= {sh[14:0], 1'b0};
              end
            end
          end
          S_DAT: begin
            if (respond && h_op[1]) begin
              mdio_out <= sh[15];
              sh       <= {sh[14:0], 1'b0};
            end else begin
              sh <= dat_full;
            end
            if (cnt == `KPCR_DATA_LAST) begin
              mdio_oe  <= 1'b0;
              mdio_out <= 1'b0;
              state    <= S_PRE;
              cnt      <= 6'h00;
              if (respond && (h_op == `KPCR_OP_ADDR)) begin
                if (h_dev == `KPCR_DEV_AN)
                  addr_an <= dat_full;
                else
                  addr_pcs <= dat_full;
              end
            end else begin
              cnt <= cnt + 6'h01;
            end
          end
          default: begin
            state <= S_PRE;
            cnt   <= 6'h00;
          end
        endcase
      end
    end
  end

  // Control registers
  always @(posedge mclk) begin
    if (rst) begin
      square_wave_run_length <= `KPCR_SQWAVE_RST;
      rx_control_char_pass   <= 1'b0;
      rx_descrambler_off     <= 1'b0;
      tx_scrambler_off       <= 1'b0;
      negotiation_reset      <= 1'b0;
      negotiation_enable     <= 1'b1;
      negotiation_restart    <= 1'b0;
      an_rsvd13              <= 1'b1;
    end else begin
      if (wr_pcs_ctrl) begin
        square_wave_run_length <=
          dat_full[`KPCR_SQWAVE_MSB:`KPCR_SQWAVE_LSB];
        rx_control_char_pass <= dat_full[`KPCR_CTRL_CHAR_BIT];
        rx_descrambler_off   <= dat_full[`KPCR_DESCR_OFF_BIT];
        tx_scrambler_off     <= dat_full[`KPCR_SCR_OFF_BIT];
      end
      negotiation_reset <= wr_an_ctrl && dat_full[`KPCR_NEGOTIATION_RESET_BIT];
      if (wr_an_ctrl) begin
        negotiation_enable <= dat_full[`KPCR_NEGOTIATION_ENABLE_BIT];
        an_rsvd13          <= dat_full[`KPCR_AN_RSVD13_BIT];
      end
      // set by write, cleared by control read
      if (wr_an_ctrl && dat_full[`KPCR_NEGOTIATION_RESTART_BIT])
        negotiation_restart <= 1'b1;
      else if (rd_an_ctrl)
        negotiation_restart <= 1'b0;
    end
  end
endmodule // kpcr_regs
